// ===== src/i2c_timeout_irq.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

module i2c_timeout_irq (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [i2c_timeout_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial bus engine events
   input wire logic serial_event,
   input wire logic status_load,
   input wire logic [7:0] status_code_in,
   input wire logic stop_sent,
   input wire logic bus_error,
   // to bus engine and cpu
   output logic bus_release,
   output logic irq_request,
   output logic irq_service
);

   i2c_timeout_pkg::timeout_ctrl_t ctrl;
   i2c_timeout_pkg::irq_enable_t irq_en;
   logic evt_flag;
   logic stop_request_bit;
   logic [7:0] bus_status_code;
   logic err_pending;
   logic [i2c_timeout_pkg::COUNT_W-1:0] count;
   logic tick;
   logic hold;
   logic overflow;
   logic wr;
   logic setup;
   logic sel_to;
   logic sel_irq;
   logic sel_evt;
   logic recover;

   // ****************************************************************
   // apb decode
   // ****************************************************************
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite;
   assign sel_to = (paddr == i2c_timeout_pkg::TIMEOUT_CTRL_ADDR);
   assign sel_irq = (paddr == i2c_timeout_pkg::SERIAL_IRQ_CTRL_ADDR);
   assign sel_evt = (paddr == i2c_timeout_pkg::SERIAL_EVENT_STAT_ADDR);

   // answer registered at setup, so access phase completes at once
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !(sel_to || sel_irq || sel_evt);
         if (setup && !pwrite) begin
            if (sel_to) begin
               prdata <= {24'h00_0000, 5'h00, ctrl.count_enable,
                          ctrl.div4, ctrl.overflow};
            end else if (sel_irq) begin
               prdata <= {30'h0000_0000, irq_en};
            end else if (sel_evt) begin
               prdata <= {16'h0000, bus_status_code, 6'h00,
                          stop_request_bit, evt_flag};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

   // ****************************************************************
   // timeout control register
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl <= i2c_timeout_pkg::TIMEOUT_CTRL_RESET;
      end else begin
         if (wr && sel_to) begin
            ctrl.count_enable <= pwdata[i2c_timeout_pkg::TO_EN_BIT];
            ctrl.div4 <= pwdata[i2c_timeout_pkg::TO_DIV_BIT];
         end
         // set wins over a software clear; writing 1 does not set
         if (overflow) begin
            ctrl.overflow <= 1'b1;
         end else if (wr && sel_to &&
                      !pwdata[i2c_timeout_pkg::TO_FLAG_BIT]) begin
            ctrl.overflow <= 1'b0;
         end
      end
   end

   // interrupt enable register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_en <= 2'h0;
      end else if (wr && sel_irq) begin
         irq_en.local_enable <= pwdata[i2c_timeout_pkg::IRQ_LOCAL_BIT];
         irq_en.global_enable <= pwdata[i2c_timeout_pkg::IRQ_GLOBAL_BIT];
      end
   end

   // ****************************************************************
   // serial event flag, stop bit, status code
   // ****************************************************************
   assign recover = err_pending && stop_request_bit && !evt_flag;

   // event flag: hardware sets, software write of 0 clears
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         evt_flag <= 1'b0;
      end else if (serial_event || bus_error) begin
         evt_flag <= 1'b1;
      end else if (wr && sel_evt &&
                   !pwdata[i2c_timeout_pkg::EVT_FLAG_BIT]) begin
         evt_flag <= 1'b0;
      end
   end

   // stop bit: software sets, hardware clears when stop is done
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stop_request_bit <= 1'b0;
      end else if (wr && sel_evt &&
                   pwdata[i2c_timeout_pkg::STOP_REQ_BIT]) begin
         stop_request_bit <= 1'b1;
      end else if (stop_sent || recover) begin
         stop_request_bit <= 1'b0;
      end
   end

   // bus error recovery waits for stop set and event flag cleared
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         err_pending <= 1'b0;
         bus_release <= 1'b0;
      end else begin
         bus_release <= bus_error || recover;
         if (bus_error) begin
            err_pending <= 1'b1;
         end else if (recover) begin
            err_pending <= 1'b0;
         end
      end
   end

   // status code: bus error forces the error code
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus_status_code <= i2c_timeout_pkg::STATUS_IDLE;
      end else if (bus_error) begin
         bus_status_code <= i2c_timeout_pkg::STATUS_BUS_ERROR;
      end else if (status_load) begin
         bus_status_code <= status_code_in;
      end
   end

   // ****************************************************************
   // timeout counter
   // ****************************************************************
   assign hold = !ctrl.count_enable || evt_flag;
   assign overflow = !hold && tick && (&count);

   timeout_prescaler u_prescaler (
      .ref_clk(ref_clk),
      .srst(srst),
      .clear(hold),
      .div4(ctrl.div4),
      .tick(tick)
   );

   // counts while enabled, zero while held, wraps and keeps going
   always_ff @(posedge ref_clk) begin
      if (srst || hold) begin
         count <= '0;
      end else if (tick) begin
         count <= count + 1'b1;
      end
   end

   // ****************************************************************
   // interrupt merge
   // ****************************************************************
   assign irq_request = evt_flag || ctrl.overflow;
   assign irq_service = irq_request && irq_en.local_enable &&
                        irq_en.global_enable;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_ovf_sets_flag: assert property (@(posedge ref_clk)
      disable iff (srst) overflow |=> ctrl.overflow && irq_request)
      else $error("overflow did not set timeout flag");

   a_hold_zero: assert property (@(posedge ref_clk) disable iff (srst)
      hold |=> count == '0)
      else $error("held counter not zero");

   a_count_step: assert property (@(posedge ref_clk) disable iff (srst)
      (!hold && tick) |=> count == $past(count) + 14'h0001)
      else $error("counter did not advance by one");

   a_div_spacing: assert property (@(posedge ref_clk) disable iff (srst)
      (tick && ctrl.div4 && !hold) |=> (!tick || !ctrl.div4) [*3])
      else $error("divided tick came too soon");

   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (srst)
      (ctrl.overflow && !(wr && sel_to)) |=> ctrl.overflow)
      else $error("timeout flag cleared without write");

   a_irq_merge: assert property (@(posedge ref_clk) disable iff (srst)
      (evt_flag || ctrl.overflow) |-> irq_request)
      else $error("flag set without interrupt request");

   a_irq_gate: assert property (@(posedge ref_clk) disable iff (srst)
      irq_service |-> irq_request && irq_en == 2'h3)
      else $error("service without both enables");

   a_stop_clear: assert property (@(posedge ref_clk) disable iff (srst)
      (stop_sent && stop_request_bit && !(wr && sel_evt))
      |=> !stop_request_bit)
      else $error("stop bit not cleared");

   a_bus_error: assert property (@(posedge ref_clk) disable iff (srst)
      bus_error |=> bus_status_code == 8'h00 && evt_flag && bus_release)
      else $error("bus error handling wrong");

endmodule

// ===== src/i2c_timeout_pkg.sv
package i2c_timeout_pkg;

   // ****************************************************************
   // register map: word indexes, byte address is four times the index
   // ****************************************************************
   localparam logic [7:0] TIMEOUT_CTRL_IDX = 8'hbf;
   localparam logic [7:0] SERIAL_IRQ_CTRL_IDX = 8'hc0;
   localparam logic [7:0] SERIAL_EVENT_STAT_IDX = 8'hc1;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] TIMEOUT_CTRL_ADDR =
      {2'h0, TIMEOUT_CTRL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] SERIAL_IRQ_CTRL_ADDR =
      {2'h0, SERIAL_IRQ_CTRL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] SERIAL_EVENT_STAT_ADDR =
      {2'h0, SERIAL_EVENT_STAT_IDX, 2'h0};

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int TO_FLAG_BIT = 0;
   localparam int TO_DIV_BIT = 1;
   localparam int TO_EN_BIT = 2;
   localparam int IRQ_LOCAL_BIT = 0;
   localparam int IRQ_GLOBAL_BIT = 1;
   localparam int EVT_FLAG_BIT = 0;
   localparam int STOP_REQ_BIT = 1;
   localparam int STATUS_LSB = 8;
   localparam logic [7:0] TIMEOUT_CTRL_RESET = 8'h00;
   localparam logic [7:0] STATUS_BUS_ERROR = 8'h00;
   localparam logic [7:0] STATUS_IDLE = 8'hf8;

   // ****************************************************************
   // timing counts
   // ****************************************************************
   localparam int COUNT_W = 14;
   localparam int DIV_SLOW = 4;
   localparam logic [1:0] PRESCALE_LAST = 2'(DIV_SLOW - 1);

   // timeout control register contents
   typedef struct packed {
      logic [4:0] reserved;
      logic count_enable;
      logic div4;
      logic overflow;
   } timeout_ctrl_t;

   // interrupt enables
   typedef struct packed {
      logic global_enable;
      logic local_enable;
   } irq_enable_t;

endpackage

// ===== src/timeout_prescaler.sv
`timescale 1ns/1ps

// ****************************************************************
// count tick generator: every clock, or every fourth clock
// ****************************************************************
module timeout_prescaler (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // control
   input wire logic clear,
   input wire logic div4,
   // tick out
   output logic tick
);

   logic [1:0] phase;

   // phase counter restarts whenever counting is held
   always_ff @(posedge ref_clk) begin
      if (srst || clear || !div4) begin
         phase <= 2'h0;
      end else if (phase == i2c_timeout_pkg::PRESCALE_LAST) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // tick on the last phase when divided, else every cycle
   assign tick = div4 ? (phase == i2c_timeout_pkg::PRESCALE_LAST) : 1'b1;

endmodule

// ===== verif/engine_model.sv
`timescale 1ns/1ps

// ****************************************************************
// serial engine stand-in: one-cycle event pulses on request
// ****************************************************************
module engine_model (
   // clock
   input wire logic ref_clk,
   // request: 1 event, 2 status load, 3 stop sent, 4 bus error
   input wire logic [2:0] kind,
   input wire logic [7:0] code,
   // event pulses
   output logic serial_event,
   output logic status_load,
   output logic [7:0] status_code_in,
   output logic stop_sent,
   output logic bus_error
);
   // quiet at time zero
   initial begin
      {serial_event, status_load, stop_sent, bus_error} = 4'h0;
      status_code_in = 8'h5a;
   end
   // code lines toggle when not loading, so a value captured a cycle late never matches
   always @(posedge ref_clk) begin
      serial_event <= (kind == 3'h1);
      status_load <= (kind == 3'h2);
      status_code_in <= (kind == 3'h2) ? code : ~status_code_in;
      stop_sent <= (kind == 3'h3);
      bus_error <= (kind == 3'h4);
   end
endmodule

// ===== verif/tb_i2c_timeout_irq.sv
`timescale 1ns/1ps

// ****************************************************************
// bench top
// ****************************************************************
module tb_i2c_timeout_irq;
   logic ref_clk, srst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic pready, pslverr, er, bus_release, irq_request, irq_service;
   logic serial_event, status_load, stop_sent, bus_error;
   logic [7:0] status_code_in, code;
   logic [2:0] kind;
   int error_cnt, tests_run, rel_cnt, n, pc;
   localparam logic [11:0] CTRL = i2c_timeout_pkg::TIMEOUT_CTRL_ADDR;
   localparam logic [11:0] IEN = i2c_timeout_pkg::SERIAL_IRQ_CTRL_ADDR;
   localparam logic [11:0] STAT = i2c_timeout_pkg::SERIAL_EVENT_STAT_ADDR;

   i2c_timeout_irq u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_event(serial_event), .status_load(status_load),
      .status_code_in(status_code_in), .stop_sent(stop_sent),
      .bus_error(bus_error), .bus_release(bus_release),
      .irq_request(irq_request), .irq_service(irq_service));
   engine_model u_eng (.ref_clk(ref_clk), .kind(kind), .code(code),
      .serial_event(serial_event), .status_load(status_load),
      .status_code_in(status_code_in), .stop_sent(stop_sent),
      .bus_error(bus_error));

   // clock, 50 ns period
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // count line-release pulses
   always @(posedge ref_clk) if (bus_release === 1'b1) rel_cnt++;

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic give_verdict();
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask

   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         chk("pready", 0, 1);
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask

   // engine request pulse
   task automatic ev(input logic [2:0] k);
      kind <= k;
      @(posedge ref_clk);
      kind <= 3'h0;
      repeat (3) @(posedge ref_clk);
   endtask

   // cycles until the interrupt request rises, bounded
   task automatic wait_irq(input int lim);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (irq_request !== 1'b1 && n < lim);
      if (irq_request !== 1'b1) begin
         chk("irq_wait", 0, 1);
         give_verdict();
      end
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {srst, psel, penable, pwrite} = 4'h8;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      kind = 3'h0;
      code = 8'h00;
      error_cnt = 0;
      tests_run = 0;
      rel_cnt = 0;
      pc = 0;
      lfsr = 32'h0001_5280;
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      rchk("ctrl_rst", CTRL, 32'h0);
      rchk("stat_rst", STAT, 32'h0000f800);
      rchk("unmapped", 12'h000, 32'h0);
      chk("slverr", {31'h0, er}, 32'h1);
      apb(1'b1, CTRL, 32'h4);
      wait_irq(17000);
      chk("ovf_fast", 32'(n >= 16383 && n <= 16388), 1);
      rchk("flag_set", CTRL, 32'h5);
      apb(1'b1, CTRL, 32'h5);
      rchk("flag_w1", CTRL, 32'h5);
      // random enable pairs against the pending request
      repeat (6) begin
         lfsr = lfsr_next(lfsr);
         apb(1'b1, IEN, {30'h0, lfsr[1:0]});
         @(negedge ref_clk);
         chk("service", {31'h0, irq_service}, {31'h0, &lfsr[1:0]});
      end
      // both enables on: the pending request must reach the cpu
      apb(1'b1, IEN, 32'h3);
      @(negedge ref_clk);
      chk("service_on", {31'h0, irq_service}, 32'h1);
      apb(1'b1, CTRL, 32'h0);
      rchk("flag_clr", CTRL, 32'h0);
      chk("irq_low", {31'h0, irq_request}, 32'h0);
      chk("service_off", {31'h0, irq_service}, 32'h0);
      apb(1'b1, CTRL, 32'h6);
      repeat (8000) @(posedge ref_clk);
      ev(3'h1);
      chk("evt_irq", {31'h0, irq_request}, 32'h1);
      rchk("evt_flag", STAT, 32'h0000f801);
      apb(1'b1, STAT, 32'h0);
      wait_irq(66000);
      chk("ovf_slow", 32'(n >= 65530 && n <= 65545), 1);
      apb(1'b1, CTRL, 32'h0);
      lfsr = lfsr_next(lfsr);
      code = lfsr[7:0];
      ev(3'h2);
      rchk("status", STAT, {16'h0, code, 8'h0});
      apb(1'b1, STAT, 32'h2);
      rchk("stop_set", STAT, {16'h0, code, 8'h2});
      ev(3'h3);
      rchk("stop_clr", STAT, {16'h0, code, 8'h0});
      ev(3'h4);
      rchk("bus_err", STAT, 32'h1);
      chk("release1", rel_cnt, 1);
      apb(1'b1, STAT, 32'h2);
      // poll the stop bit until hardware drops it, bounded
      pc = 0;
      do begin
         apb(1'b0, STAT, 32'h0);
         pc++;
      end while (rd[1] !== 1'b0 && pc < 8);
      if (rd[1] !== 1'b0) begin
         chk("stop_poll", 0, 1);
         give_verdict();
      end
      rchk("recover", STAT, 32'h0);
      chk("release2", rel_cnt, 2);
      give_verdict();
   end
endmodule
